// *** rtl/qpis_core.sv ***
// Purpose: Four-phase fetch/execute sequencer with oscillator pin roles
// Assumes: All inputs except presetn synchronous to pclk; program memory answers combinationally
// Notes:   APB slave with zero wait states; unmapped addresses answer pslverr
//
// Chosen here: the register addresses and the APB register port.

`timescale 1ns/1ps
`default_nettype none

module qpis_core
    import qpis_pkg::*;
#(
    parameter int PC_W = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Program memory
    output logic [PC_W-1:0] pmem_addr,
    input wire logic [QPIS_IW-1:0] pmem_data,
    // Data memory
    output logic [6:0] dmem_raddr,
    output logic dmem_rd,
    input wire logic [7:0] dmem_rdata,
    output qpis_dwr_type dmem_wr,
    // Shared pins
    input wire logic master_clear_n,
    input wire logic gp_four_i,
    output logic gp_four_o,
    output logic gp_four_oe,
    input wire logic gp_five_i,
    output logic gp_five_o,
    output logic gp_five_oe,
    output logic osc_output_pin_en,
    output logic osc_input_pin_en
);

    initial begin
        if (PC_W < 1 || PC_W > 11) begin
            $error("PC_W must be 1 to 11");
        end
    end

    function automatic logic is_jump(input logic [QPIS_IW-1:0] w);
        return w[13:11] == QPIS_JUMP_OP;
    endfunction : is_jump

    function automatic logic is_byte(input logic [QPIS_IW-1:0] w);
        return w[13:12] == QPIS_BYTE_OP && w[11:8] != QPIS_FN_NONE;
    endfunction : is_byte

    function automatic logic is_xtal(input qpis_osc_type m);
        return m == OSC_LOW_POWER_XTAL || m == OSC_STD_XTAL || m == OSC_HIGH_SPEED_XTAL;
    endfunction : is_xtal

    // ==========================================================
    // Phases and control
    qpis_phase_type phase;
    qpis_ctrl_type ctrl_q;
    logic [3:0] gpio_q;
    logic master_clear_n_hit;
    logic active;

    qpis_phase_gen u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .phase(phase)
    );

    assign master_clear_n_hit = ctrl_q.master_clear_n_en && !master_clear_n;
    assign active = ctrl_q.run && !master_clear_n_hit;

    // ==========================================================
    // Pipeline state
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] faddr_q;
    logic [QPIS_IW-1:0] fetch_q;
    logic fetch_valid_q;
    logic [QPIS_IW-1:0] ir_q;
    logic [7:0] w_q;
    logic [7:0] result_q;
    logic jump_now;

    assign jump_now = active && phase == PHASE_FOUR && is_jump(ir_q);

    // Program counter: step at phase one, load target at end of a jump
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= '0;
            faddr_q <= '0;
        end else if (master_clear_n_hit) begin
            pc_q <= '0;
            faddr_q <= '0;
        end else if (active && phase == PHASE_ONE) begin
            faddr_q <= pc_q;
            pc_q <= pc_q + 1'b1;
        end else if (jump_now) begin
            pc_q <= ir_q[PC_W-1:0];
        end
    end

    assign pmem_addr = faddr_q;

    // Fetch register; a jump invalidates the word fetched alongside it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_q <= QPIS_NOP;
            fetch_valid_q <= 1'b0;
        end else if (master_clear_n_hit) begin
            fetch_q <= QPIS_NOP;
            fetch_valid_q <= 1'b0;
        end else if (active && phase == PHASE_FOUR) begin
            fetch_q <= pmem_data;
            fetch_valid_q <= !is_jump(ir_q);
        end
    end

    // Instruction register loads at phase one, so fetch and execute overlap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_q <= QPIS_NOP;
        end else if (master_clear_n_hit) begin
            ir_q <= QPIS_NOP;
        end else if (active && phase == PHASE_ONE) begin
            ir_q <= fetch_valid_q ? fetch_q : QPIS_NOP;
        end
    end

    // ==========================================================
    // Execute: operand read in phase two, result registered at the end of phase two
    assign dmem_raddr = ir_q[6:0];
    assign dmem_rd = active && phase == PHASE_TWO && is_byte(ir_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 8'h00;
        end else if (dmem_rd) begin
            unique case (ir_q[11:8])
                QPIS_FN_INC: result_q <= dmem_rdata + 8'h01;
                QPIS_FN_DEC: result_q <= dmem_rdata - 8'h01;
                QPIS_FN_COMP: result_q <= ~dmem_rdata;
                default: result_q <= dmem_rdata;
            endcase
        end
    end

    // Destination write in phase four, to data memory or the accumulator
    always_comb begin
        dmem_wr.we = active && phase == PHASE_FOUR && is_byte(ir_q) && ir_q[7];
        dmem_wr.addr = ir_q[6:0];
        dmem_wr.data = result_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_q <= 8'h00;
        end else if (active && phase == PHASE_FOUR && is_byte(ir_q) && !ir_q[7]) begin
            w_q <= result_q;
        end
    end

    // ==========================================================
    // Shared pins
    logic instr_rate_clock_out_mode;

    assign instr_rate_clock_out_mode = ctrl_q.instr_rate_clock_out_en
        && (ctrl_q.mode == OSC_EXTERNAL_RC || ctrl_q.mode == OSC_INTERNAL_RC);

    // High during phases one and two, one pulse per instruction cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gp_four_o <= 1'b0;
            gp_five_o <= 1'b0;
        end else begin
            gp_four_o <= instr_rate_clock_out_mode ? (phase == PHASE_FOUR || phase == PHASE_ONE)
                                     : gpio_q[QPIS_GPIO_OUT_POS];
            gp_five_o <= gpio_q[QPIS_GPIO_OUT_POS+1];
        end
    end

    // Crystal pins are analog; the digital driver must stay off
    assign osc_output_pin_en = is_xtal(ctrl_q.mode);
    assign gp_four_oe = !is_xtal(ctrl_q.mode) && (instr_rate_clock_out_mode || gpio_q[QPIS_GPIO_DIR_POS]);
    assign osc_input_pin_en = ctrl_q.mode != OSC_INTERNAL_RC;
    assign gp_five_oe = ctrl_q.mode == OSC_INTERNAL_RC && gpio_q[QPIS_GPIO_DIR_POS+1];

    // ==========================================================
    // APB slave, zero wait states
    logic wr_en;
    logic mapped;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign mapped = paddr == QPIS_CTRL_OFS || paddr == QPIS_GPIO_OFS
        || paddr == QPIS_STAT_OFS || paddr == QPIS_IR_OFS || paddr == QPIS_WREG_OFS;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= QPIS_CTRL_RST;
        end else if (wr_en && paddr == QPIS_CTRL_OFS) begin
            ctrl_q.mode <= qpis_osc_type'(pwdata[QPIS_CTRL_MODE_POS +: 3]);
            ctrl_q.instr_rate_clock_out_en <= pwdata[QPIS_CTRL_CKO_POS];
            ctrl_q.master_clear_n_en <= pwdata[QPIS_CTRL_MASTER_CLEAR_N_POS];
            ctrl_q.run <= pwdata[QPIS_CTRL_RUN_POS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_q <= 4'h0;
        end else if (wr_en && paddr == QPIS_GPIO_OFS) begin
            gpio_q <= pwdata[3:0];
        end
    end

    // Read data is registered in the setup cycle so it is valid in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                QPIS_CTRL_OFS: begin
                    prdata[QPIS_CTRL_MODE_POS +: 3] <= ctrl_q.mode;
                    prdata[QPIS_CTRL_CKO_POS] <= ctrl_q.instr_rate_clock_out_en;
                    prdata[QPIS_CTRL_MASTER_CLEAR_N_POS] <= ctrl_q.master_clear_n_en;
                    prdata[QPIS_CTRL_RUN_POS] <= ctrl_q.run;
                end
                QPIS_GPIO_OFS: begin
                    prdata[3:0] <= gpio_q;
                    prdata[QPIS_GPIO_IN_POS] <= gp_four_i;
                    prdata[QPIS_GPIO_IN_POS+1] <= gp_five_i;
                end
                QPIS_STAT_OFS: begin
                    prdata[3:0] <= phase;
                    prdata[QPIS_STAT_FLUSH_POS] <= !fetch_valid_q;
                    prdata[QPIS_STAT_PC_POS +: PC_W] <= pc_q;
                end
                QPIS_IR_OFS: prdata[QPIS_IW-1:0] <= ir_q;
                QPIS_WREG_OFS: prdata[7:0] <= w_q;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_PC_STEP: assert property (active && phase == PHASE_ONE |=>
        pc_q == $past(pc_q) + 1'b1 && faddr_q == $past(pc_q))
        else $error("pc did not step at phase one");

    AST_PC_HOLD: assert property (!master_clear_n_hit && phase != PHASE_ONE && !jump_now |=>
        $stable(pc_q))
        else $error("pc moved outside phase one");

    AST_FETCH_CAPTURE: assert property (active && phase == PHASE_FOUR |=>
        fetch_q == $past(pmem_data))
        else $error("fetch word not captured at phase four");

    AST_IR_LOAD: assert property (active && phase == PHASE_ONE |=>
        ir_q == ($past(fetch_valid_q) ? $past(fetch_q) : QPIS_NOP)
            ##1 ($stable(ir_q) || $past(master_clear_n_hit))[*3])
        else $error("instruction register load wrong");

    AST_JUMP_TWO_CYCLES: assert property (jump_now ##1 active |=>
        ir_q == QPIS_NOP && pc_q == $past(ir_q[PC_W-1:0], 2) + 1'b1)
        else $error("jump did not insert a no-op cycle");

    AST_FLUSH: assert property (jump_now |=> !fetch_valid_q)
        else $error("overlapped fetch not discarded");

    AST_READ_PHASE: assert property (dmem_rd |-> phase == PHASE_TWO ##2 phase == PHASE_FOUR)
        else $error("operand read outside phase two");

    AST_WRITE_PHASE: assert property (dmem_wr.we |-> phase == PHASE_FOUR
        && $past(phase, 2) == PHASE_TWO)
        else $error("destination write outside phase four");

    AST_INSTR_RATE_CLOCK_OUT_RATE: assert property ($rose(gp_four_o) && instr_rate_clock_out_mode ##1
        $stable(ctrl_q)[*3] |-> ##1 $rose(gp_four_o))
        else $error("clock out not a quarter rate");

    AST_XTAL_PIN: assert property (is_xtal(ctrl_q.mode) |-> !gp_four_oe && osc_output_pin_en)
        else $error("gp_four driven in crystal mode");

    AST_GP_FIVE_ROLE: assert property (ctrl_q.mode != OSC_INTERNAL_RC |-> !gp_five_oe)
        else $error("gp_five driven while oscillator input");

    AST_MASTER_CLEAR_N: assert property (master_clear_n_hit |=> pc_q == '0 && ir_q == QPIS_NOP && !fetch_valid_q)
        else $error("master clear did not reset sequencer");

    COV_JUMP: cover property (jump_now ##4 active && phase == PHASE_ONE);
    COV_WRITE: cover property (dmem_wr.we);
    COV_INSTR_RATE_CLOCK_OUT: cover property (instr_rate_clock_out_mode && $rose(gp_four_o));
    COV_MASTER_CLEAR_N: cover property (ctrl_q.run && master_clear_n_hit);

endmodule : qpis_core

`default_nettype wire

// *** rtl/qpis_phase_gen.sv ***
// Purpose: Divide the input clock by four into four one-hot phases
// Assumes: presetn asynchronous, active low
// Notes:   Phase one is active in the first cycle after reset release

`timescale 1ns/1ps
`default_nettype none

module qpis_phase_gen
    import qpis_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Phase
    output qpis_phase_type phase
);

    qpis_phase_type phase_q;
    qpis_phase_type phase_d;

    always_comb begin
        unique case (phase_q)
            PHASE_ONE: phase_d = PHASE_TWO;
            PHASE_TWO: phase_d = PHASE_THREE;
            PHASE_THREE: phase_d = PHASE_FOUR;
            PHASE_FOUR: phase_d = PHASE_ONE;
            default: phase_d = PHASE_ONE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= PHASE_ONE;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;

    AST_PHASE_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        phase_q == PHASE_ONE |=> phase_q == PHASE_TWO ##1 phase_q == PHASE_THREE
            ##1 phase_q == PHASE_FOUR ##1 phase_q == PHASE_ONE)
        else $error("phases out of order");

    AST_PHASE_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot(phase_q))
        else $error("phase not one-hot");

endmodule : qpis_phase_gen

`default_nettype wire

// *** rtl/qpis_pkg.sv ***
// Purpose: Shared constants and types of the quad phase instruction sequencer
// Assumes: 32-bit APB register bus, 14-bit instruction words, 8-bit data memory
// Notes:   Register offsets are byte addresses

package qpis_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] QPIS_CTRL_OFS = 8'h00;
    localparam logic [7:0] QPIS_GPIO_OFS = 8'h04;
    localparam logic [7:0] QPIS_STAT_OFS = 8'h08;
    localparam logic [7:0] QPIS_IR_OFS = 8'h0C;
    localparam logic [7:0] QPIS_WREG_OFS = 8'h10;

    // Control fields: mode[2:0], clock out enable, master clear enable, run
    localparam int QPIS_CTRL_MODE_POS = 0;
    localparam int QPIS_CTRL_CKO_POS = 3;
    localparam int QPIS_CTRL_MASTER_CLEAR_N_POS = 4;
    localparam int QPIS_CTRL_RUN_POS = 5;
    // Pin fields: out[1:0] then drive[3:2]; bit 0 is gp_four, bit 1 is gp_five
    localparam int QPIS_GPIO_OUT_POS = 0;
    localparam int QPIS_GPIO_DIR_POS = 2;
    localparam int QPIS_GPIO_IN_POS = 4;
    // Status fields: phase[3:0], flush, pc from bit 8
    localparam int QPIS_STAT_FLUSH_POS = 4;
    localparam int QPIS_STAT_PC_POS = 8;

    // ==========================================================
    // Oscillator modes
    typedef enum logic [2:0] {
        OSC_LOW_POWER_XTAL = 3'h0,
        OSC_STD_XTAL = 3'h1,
        OSC_HIGH_SPEED_XTAL = 3'h2,
        OSC_INTERNAL_RC = 3'h4,
        OSC_EXTERNAL_RC = 3'h5
    } qpis_osc_type;

    typedef struct packed {
        logic run;
        logic master_clear_n_en;
        logic instr_rate_clock_out_en;
        qpis_osc_type mode;
    } qpis_ctrl_type;

    localparam qpis_ctrl_type QPIS_CTRL_RST = '{run: 1'b0, master_clear_n_en: 1'b1, instr_rate_clock_out_en: 1'b0,
                                                mode: OSC_STD_XTAL};

    // One-hot phase state
    typedef enum logic [3:0] {
        PHASE_ONE = 4'h1,
        PHASE_TWO = 4'h2,
        PHASE_THREE = 4'h4,
        PHASE_FOUR = 4'h8
    } qpis_phase_type;

    // ==========================================================
    // Instruction encoding
    localparam int QPIS_IW = 14;
    localparam logic [13:0] QPIS_NOP = 14'h0000;
    localparam logic [2:0] QPIS_JUMP_OP = 3'h5;
    localparam logic [1:0] QPIS_BYTE_OP = 2'h0;
    localparam logic [3:0] QPIS_FN_NONE = 4'h0;
    localparam logic [3:0] QPIS_FN_DEC = 4'h3;
    localparam logic [3:0] QPIS_FN_MOVE = 4'h8;
    localparam logic [3:0] QPIS_FN_COMP = 4'h9;
    localparam logic [3:0] QPIS_FN_INC = 4'hA;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } qpis_dwr_type;

endpackage : qpis_pkg

// *** test/qpis_mem_model.sv ***
// Purpose: Program and data memory facing the sequencer core
// Assumes: Combinational reads, data write at the clock edge while we is high
// Notes:   The bench fills both arrays by hierarchical reference

`timescale 1ns/1ps
`default_nettype none

module qpis_mem_model
    import qpis_pkg::*;
#(
    parameter int PC_W = 4
) (
    // Clock
    input wire logic pclk,
    // Program memory
    input wire logic [PC_W-1:0] pmem_addr,
    output logic [QPIS_IW-1:0] pmem_data,
    // Data memory
    input wire logic [6:0] dmem_raddr,
    input wire logic dmem_rd,
    output logic [7:0] dmem_rdata,
    input wire qpis_dwr_type dmem_wr
);
    logic [QPIS_IW-1:0] pmem [0:(1<<PC_W)-1];
    logic [7:0] dmem [0:127];

    // ==========================================================
    // Access
    assign pmem_data = pmem[pmem_addr];
    // Outside the strobe the model drives the inverted word, so a late sample is caught
    assign dmem_rdata = dmem_rd ? dmem[dmem_raddr] : ~dmem[dmem_raddr];

    // Plain always: the bench also preloads this array by hierarchical reference
    always @(posedge pclk) begin
        if (dmem_wr.we) begin
            dmem[dmem_wr.addr] <= dmem_wr.data;
        end
    end
endmodule : qpis_mem_model

`default_nettype wire

// *** test/tb_quad_phase_instruction_cycle.sv ***
// Purpose: Self-checking bench of the four-phase sequencer core
// Assumes: Zero-wait APB, memories answer combinationally
// Notes:   PC_W is cut to 4 so the program fits a tiny memory

`timescale 1ns/1ps
`default_nettype none

module tb_quad_phase_instruction_cycle;
    import qpis_pkg::*;
    localparam int PW = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [PW-1:0] pmem_addr, last_addr;
    logic [QPIS_IW-1:0] pmem_data;
    logic [6:0] dmem_raddr;
    logic dmem_rd, master_clear_n, ext_four, ext_five;
    logic [7:0] dmem_rdata;
    qpis_dwr_type dmem_wr;
    logic gp_four_i, gp_four_o, gp_four_oe, gp_five_i, gp_five_o, gp_five_oe;
    logic osc_output_pin_en, osc_input_pin_en;
    int num_errors = 0, n_compared = 0, cyc = 0, t_chg = 0, t_rd = 0, t_w10 = 0, t_w12 = 0;
    logic [PW-1:0] fetch_q [$];

    // Pin level from whoever drives it
    assign gp_four_i = gp_four_oe ? gp_four_o : ext_four;
    assign gp_five_i = gp_five_oe ? gp_five_o : ext_five;

    qpis_core #(.PC_W(PW)) qpis_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .dmem_raddr(dmem_raddr), .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata),
        .dmem_wr(dmem_wr), .master_clear_n(master_clear_n), .gp_four_i(gp_four_i),
        .gp_four_o(gp_four_o), .gp_four_oe(gp_four_oe), .gp_five_i(gp_five_i),
        .gp_five_o(gp_five_o), .gp_five_oe(gp_five_oe),
        .osc_output_pin_en(osc_output_pin_en), .osc_input_pin_en(osc_input_pin_en));

    qpis_mem_model #(.PC_W(PW)) qpis_mem_model_inst (.pclk(pclk), .pmem_addr(pmem_addr),
        .pmem_data(pmem_data), .dmem_raddr(dmem_raddr), .dmem_rd(dmem_rd),
        .dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ==========================================================
    // Monitors
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        last_addr <= pmem_addr;
        if (presetn && pmem_addr !== last_addr) begin
            fetch_q.push_back(pmem_addr);
            // Master clear moves the fetch address off the phase grid, so spacing restarts
            if (master_clear_n && t_chg != 0 && (cyc - t_chg) % 4 != 0) begin
                chk(32'(cyc - t_chg), 32'h4);
            end
            t_chg <= cyc;
        end
        if (!master_clear_n) t_chg <= 0;
        if (dmem_rd && dmem_raddr == 7'h10) t_rd <= cyc;
        if (dmem_wr.we && dmem_wr.addr == 7'h10) t_w10 <= cyc;
        if (dmem_wr.we && dmem_wr.addr == 7'h12) t_w12 <= cyc;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic test_done();
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd = prdata;
                er = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                return;
            end
        end
        num_errors++;
        test_done();
    endtask : apb

    // ==========================================================
    // Scenarios
    task automatic check_reset();
        apb(1'b0, QPIS_CTRL_OFS, 32'h0);
        chk(rd, 32'h11);
        chk(osc_output_pin_en & osc_input_pin_en, 1);
        apb(1'b0, QPIS_GPIO_OFS, 32'h0);
        chk(rd, 32'h10);
        apb(1'b0, 8'h20, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
    endtask : check_reset

    task automatic check_program();
        logic [PW-1:0] exp_f [6] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h5};
        qpis_mem_model_inst.pmem[0] = 14'h0A90;
        qpis_mem_model_inst.pmem[1] = 14'h2804;
        qpis_mem_model_inst.pmem[2] = 14'h0A91;
        qpis_mem_model_inst.pmem[4] = 14'h0392;
        qpis_mem_model_inst.pmem[5] = 14'h2805;
        qpis_mem_model_inst.dmem[16] = 8'h05;
        qpis_mem_model_inst.dmem[17] = 8'h20;
        qpis_mem_model_inst.dmem[18] = 8'h40;
        fetch_q.delete();
        apb(1'b1, QPIS_CTRL_OFS, 32'h31);
        repeat (40) @(posedge pclk);
        apb(1'b1, QPIS_CTRL_OFS, 32'h11);
        chk(qpis_mem_model_inst.dmem[16], 32'h06);
        chk(qpis_mem_model_inst.dmem[17], 32'h20);
        chk(qpis_mem_model_inst.dmem[18], 32'h3F);
        chk(32'(t_w10 - t_rd), 32'h2);
        chk(32'(t_w12 - t_w10), 32'hC);
        chk(fetch_q.size() >= 6, 1);
        for (int i = 0; i < 6; i++) chk(fetch_q[i], exp_f[i]);
    endtask : check_program

    task automatic check_master_clear_n();
        apb(1'b1, QPIS_CTRL_OFS, 32'h31);
        repeat (12) @(posedge pclk);
        master_clear_n <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, QPIS_STAT_OFS, 32'h0);
        chk(rd[QPIS_STAT_PC_POS +: PW], 0);
        chk($countones(rd[3:0]), 1);
        master_clear_n <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b1, QPIS_CTRL_OFS, 32'h21);
        master_clear_n <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, QPIS_STAT_OFS, 32'h0);
        chk(rd[QPIS_STAT_PC_POS +: PW] != 0, 1);
        master_clear_n <= 1'b1;
        apb(1'b1, QPIS_CTRL_OFS, 32'h11);
    endtask : check_master_clear_n

    task automatic check_modes();
        logic [2:0] m [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
        apb(1'b1, QPIS_GPIO_OFS, 32'h0F);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, QPIS_CTRL_OFS, {27'h0, 2'b10, m[i]});
            @(negedge pclk);
            chk({osc_output_pin_en, gp_four_oe}, {m[i] < 3, m[i] >= 3});
            chk({osc_input_pin_en, gp_five_oe}, {m[i] != 4, m[i] == 4});
        end
        apb(1'b1, QPIS_CTRL_OFS, 32'h14);
        apb(1'b0, QPIS_GPIO_OFS, 32'h0);
        chk(rd, 32'h3F);
    endtask : check_modes

    task automatic check_instr_rate_clock_out();
        logic s [8];
        for (int k = 4; k < 6; k++) begin
            apb(1'b1, QPIS_CTRL_OFS, 32'h18 | k);
            // The first cycle after the write still shows the old pin source
            @(negedge pclk);
            for (int i = 0; i < 8; i++) begin
                @(negedge pclk);
                s[i] = gp_four_o;
            end
            chk(gp_four_oe, 1);
            chk({s[0] ^ s[2], s[4] ^ s[2], s[0] ^ s[1] ^ s[2] ^ s[3]}, 3'b110);
            chk({s[1] ^ s[3], s[1] ^ s[5], s[3] ^ s[7]}, 3'b100);
        end
        apb(1'b1, QPIS_CTRL_OFS, 32'h19);
        @(negedge pclk);
        chk(gp_four_oe, 0);
    endtask : check_instr_rate_clock_out

    // ==========================================================
    // Main sequence
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        master_clear_n = 1'b1;
        ext_four = 1'b1;
        ext_five = 1'b0;
        for (int i = 0; i < 16; i++) qpis_mem_model_inst.pmem[i] = QPIS_NOP;
        for (int i = 0; i < 128; i++) qpis_mem_model_inst.dmem[i] = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check_reset();
        check_program();
        check_master_clear_n();
        check_modes();
        check_instr_rate_clock_out();
        test_done();
    end
endmodule : tb_quad_phase_instruction_cycle

`default_nettype wire
